//--- verilog/fsc_pkg.sv
// Purpose: Shared constants for the flash security and command control ends.
// Assumes: One 20 MHz clock; register index space of 16 words on the link.
// Notes:   Summary of the expected behaviour follows.
// Summary of operation
// - Lock bit 0 set by one, key needed
// - Lock clears only on power-on/pin reset or erase (code: clean mass erase or blank check)
// - Locked data-bus user reads fault, data zero
// - Locked instruction-fetch user reads fault, data zero
// - Locked user-space write commands are denied
// - Locked device still runs mass and page erase
// - Protected pages never erased; mass erase refused
// - Volatile config returns to reset on every reset
// - Key precedes volatile config write; else ignored
// - Remap bit aliases info space at address zero
// - Writing one clears remap; boot loader clears it
// - Command field bits 3:0 starts operation; key needed (code lets write 0x4 start without key)
// - Code 0 keyless, does nothing, wakes sleeping flash
// - Code 1 with key aborts, reports abort error
// - Only abort overlaps; one write queues behind write
// - Abort may be declined; command then finishes normally
// - After abort, software verifies and reprograms region
// - Software aborts rarely, last resort only
// - Abort ending or waking reports failure code 0x3
// - Key unlocked only by value 0x676c7565
// - Sleeping flash wakes on any bus transaction (code: only code-bus reads, dma_req, command codes 0 or 1, or a command that starts an operation wake it)
package fsc_pkg;
  // Key and register indexes on the link
  localparam logic [31:0] USER_KEY   = 32'h676c7565;
  localparam int          REG_IDX_W  = 4;
  localparam logic [3:0]  REG_KEY    = 4'h0;
  localparam logic [3:0]  REG_LOCK   = 4'h1;
  localparam logic [3:0]  REG_VCFG   = 4'h2;
  localparam logic [3:0]  REG_CMD    = 4'h3;
  localparam logic [3:0]  REG_STAT   = 4'h4;
  localparam logic [3:0]  REG_WRPROT = 4'h5;
  localparam logic [3:0]  REG_COUNT  = 4'h6;

  // Field positions
  localparam int LOCK_BIT      = 0;
  localparam int REMAP_BIT     = 0;
  localparam int CMD_LSB       = 0;
  localparam int CMD_W         = 4;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_DONE     = 1;
  localparam int STAT_FAIL_LSB = 4;
  localparam int STAT_SLEEP    = 8;
  localparam int STAT_KEY      = 9;
  localparam int AUTO_KEY_BIT  = 0;

  // Reset values
  localparam logic        REMAP_RESET    = 1'b1;
  localparam logic [31:0] WRPROT_RESET   = 32'h0;
  localparam logic        AUTO_KEY_RESET = 1'b0;

  // Command codes
  localparam logic [3:0] CMD_IDLE        = 4'h0;
  localparam logic [3:0] CMD_ABORT       = 4'h1;
  localparam logic [3:0] CMD_SLEEP       = 4'h2;
  localparam logic [3:0] CMD_SIGN        = 4'h3;
  localparam logic [3:0] CMD_WRITE       = 4'h4;
  localparam logic [3:0] CMD_PAGE_ERASE  = 4'h5;
  localparam logic [3:0] CMD_MASS_ERASE  = 4'h6;
  localparam logic [3:0] CMD_BLANK_CHECK = 4'h7;

  // Failure codes in the status field
  localparam logic [1:0] FAIL_NONE    = 2'h0;
  localparam logic [1:0] FAIL_DENIED  = 2'h1;
  localparam logic [1:0] FAIL_INVALID = 2'h2;
  localparam logic [1:0] FAIL_ABORT   = 2'h3;

  // Code-bus address map
  localparam int          ADDR_W     = 20;
  localparam int          PAGE_W     = 5;
  localparam logic [19:0] USER_TOP   = 20'h80000;
  localparam logic [19:0] INFO_BASE  = 20'h80000;
  localparam logic [19:0] REMAP_SPAN = 20'h04000;

  // Host bus map
  localparam int         AXI_ADDR_W    = 8;
  localparam logic [5:0] HOST_CTRL_IDX = 6'h10;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage

//--- verilog/fsc_if.sv
// Purpose: Register link between the bus bridge and the flash control end.
// Assumes: sel held by the host until ack; ack is a one-cycle pulse.
// Notes:   rdata valid in the ack cycle of a read.
`timescale 1ns/1ps
interface fsc_if;
  import fsc_pkg::*;
  logic                 sel;
  logic                 wr;
  logic [REG_IDX_W-1:0] addr;
  logic [31:0]          wdata;
  logic [31:0]          rdata;
  logic                 ack;

  modport dev (input sel, input wr, input addr, input wdata, output rdata, output ack);
  modport host (output sel, output wr, output addr, output wdata, input rdata, input ack);
endinterface

//--- verilog/fsc_flash_end.sv
// Purpose: Flash security lock, boot alias and command sequencing end.
// Assumes: Array data combinational on arr_addr; engine pulses op_done.
// Notes:   Port index 0 is the instruction_fetch_bus, 1 the data_fetch_bus.
`timescale 1ns/1ps
module fsc_flash_end (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        por_pin_rstn,
  fsc_if.dev                               link,
  input  wire logic                        rd_valid [2],
  input  wire logic [fsc_pkg::ADDR_W-1:0]  rd_addr  [2],
  output logic                             rd_ready [2],
  output logic                             rd_rvalid [2],
  output logic                             rd_fault [2],
  output logic [31:0]                      rd_data  [2],
  input  wire logic                        dma_req,
  output logic [fsc_pkg::ADDR_W-1:0]       arr_addr [2],
  input  wire logic [31:0]                 arr_rdata [2],
  output logic                             op_start,
  output logic [fsc_pkg::CMD_W-1:0]        op_code,
  output logic                             op_abort,
  input  wire logic                        op_done,
  input  wire logic                        op_ok,
  input  wire logic                        abort_ok,
  input  wire logic                        target_user,
  input  wire logic [fsc_pkg::PAGE_W-1:0]  target_page,
  output logic                             sleeping
);
  import fsc_pkg::*;

  typedef enum logic [2:0] {
    ST_READY = 3'b001,
    ST_RUN   = 3'b010,
    ST_SLEEP = 3'b100
  } fsc_state_t;

  fsc_state_t         st_q;
  fsc_state_t         st_d;
  logic               ack_q;
  logic [31:0]        rdata_q;
  logic               key_ok_q;
  logic               user_space_lock_q;
  logic               boot_space_alias_q;
  logic [31:0]        page_write_protect_q;
  logic               done_q;
  logic [1:0]         fail_q;
  logic               pend_q;
  logic [CMD_W-1:0]   cur_q;
  logic               op_start_q;
  logic               op_abort_q;
  logic               acc;
  logic               wr;
  logic               cmd_wr;
  logic [CMD_W-1:0]   cmd_code;
  logic               need_key;
  logic               start;
  logic [CMD_W-1:0]   start_code;
  logic               done_set;
  logic [1:0]         fail_d;
  logic               pend_set;
  logic               pend_clr;
  logic               abort_req;
  logic               lock_clr;
  logic               wake_req;
  logic [31:0]        stat_word;

  // Alias a low address onto info space while the remap bit stands
  function automatic logic [ADDR_W-1:0] map_addr(input logic [ADDR_W-1:0] a, input logic alias_on);
    if (alias_on && a < REMAP_SPAN) begin
      map_addr = INFO_BASE + a;
    end else begin
      map_addr = a;
    end
  endfunction

  // Physical address lies in user space
  function automatic logic in_user(input logic [ADDR_W-1:0] a);
    in_user = a < USER_TOP;
  endfunction

  // Register access; held off one cycle when the engine finishes
  assign acc      = link.sel & ~ack_q & ~(st_q == ST_RUN && op_done);
  assign wr       = acc & link.wr;
  assign cmd_wr   = wr && link.addr == REG_CMD;
  assign cmd_code = link.wdata[CMD_LSB +: CMD_W];
  assign need_key = cmd_code != CMD_IDLE && cmd_code != CMD_WRITE;
  assign wake_req = rd_valid[0] | rd_valid[1] | dma_req;

  // Link answer and read data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= acc;
      if (acc && !link.wr) begin
        unique case (link.addr)
          REG_LOCK:   rdata_q <= {31'h0, user_space_lock_q};
          REG_VCFG:   rdata_q <= {31'h0, boot_space_alias_q};
          REG_CMD:    rdata_q <= {28'h0, cur_q};
          REG_STAT:   rdata_q <= stat_word;
          REG_WRPROT: rdata_q <= page_write_protect_q;
          default:    rdata_q <= 32'h0;
        endcase
      end
    end
  end
  assign link.ack   = ack_q;
  assign link.rdata = rdata_q;

  always_comb begin
    stat_word                            = 32'h0;
    stat_word[STAT_BUSY]                 = st_q == ST_RUN;
    stat_word[STAT_DONE]                 = done_q;
    stat_word[STAT_FAIL_LSB +: 2]        = fail_q;
    stat_word[STAT_SLEEP]                = st_q == ST_SLEEP;
    stat_word[STAT_KEY]                  = key_ok_q;
  end

  // Key: only the exact value unlocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_ok_q <= 1'b0;
    end else if (wr && link.addr == REG_KEY) begin
      key_ok_q <= link.wdata == USER_KEY;
    end
  end

  // Security lock, cleared only by its own reset or a clean mass erase or blank check
  always_ff @(posedge aclk) begin
    if (!por_pin_rstn) begin
      user_space_lock_q <= 1'b0;
    end else if (wr && link.addr == REG_LOCK && key_ok_q && link.wdata[LOCK_BIT]) begin
      user_space_lock_q <= 1'b1;
    end else if (lock_clr) begin
      user_space_lock_q <= 1'b0;
    end
  end

  // Volatile config and page protection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_space_alias_q   <= REMAP_RESET;
      page_write_protect_q <= WRPROT_RESET;
    end else begin
      if (wr && link.addr == REG_VCFG && key_ok_q && link.wdata[REMAP_BIT]) begin
        boot_space_alias_q <= 1'b0;
      end
      if (wr && link.addr == REG_WRPROT && key_ok_q) begin
        page_write_protect_q <= link.wdata;
      end
    end
  end

  // Command decision
  always_comb begin
    st_d       = st_q;
    start      = 1'b0;
    start_code = cmd_code;
    done_set   = 1'b0;
    fail_d     = FAIL_NONE;
    pend_set   = 1'b0;
    pend_clr   = 1'b0;
    abort_req  = 1'b0;
    lock_clr   = 1'b0;
    if (st_q == ST_RUN && op_done) begin
      if (pend_q) begin
        start      = 1'b1;
        start_code = CMD_WRITE;
        pend_clr   = 1'b1;
      end else begin
        st_d     = ST_READY;
        done_set = 1'b1;
        fail_d   = op_ok ? FAIL_NONE : FAIL_DENIED;
        lock_clr = op_ok && (cur_q == CMD_MASS_ERASE || cur_q == CMD_BLANK_CHECK);
      end
    end else if (cmd_wr) begin
      if (need_key && !key_ok_q) begin
        done_set = 1'b1;
        fail_d   = FAIL_DENIED;
      end else if (cmd_code == CMD_ABORT) begin
        abort_req = st_q == ST_RUN;
        if (st_q != ST_RUN || abort_ok) begin
          st_d     = ST_READY;
          done_set = 1'b1;
          fail_d   = FAIL_ABORT;
          pend_clr = 1'b1;
        end
      end else if (st_q == ST_RUN) begin
        if (cmd_code == CMD_WRITE && cur_q == CMD_WRITE && !pend_q && !(user_space_lock_q && target_user)) begin
          pend_set = 1'b1;
        end else begin
          done_set = 1'b1;
          fail_d   = FAIL_INVALID;
        end
      end else if (cmd_code == CMD_IDLE) begin
        st_d     = ST_READY;
        done_set = 1'b1;
      end else if (cmd_code == CMD_WRITE && user_space_lock_q && target_user) begin
        done_set = 1'b1;
        fail_d   = FAIL_DENIED;
      end else if ((cmd_code == CMD_PAGE_ERASE && page_write_protect_q[target_page]) ||
                   (cmd_code == CMD_MASS_ERASE && |page_write_protect_q)) begin
        done_set = 1'b1;
        fail_d   = FAIL_DENIED;
      end else if (cmd_code == CMD_SLEEP) begin
        st_d     = ST_SLEEP;
        done_set = 1'b1;
      end else if (cmd_code >= CMD_SIGN && cmd_code <= CMD_BLANK_CHECK) begin
        start = 1'b1;
        st_d  = ST_RUN;
      end else begin
        done_set = 1'b1;
        fail_d   = FAIL_INVALID;
      end
    end else if (st_q == ST_SLEEP && wake_req) begin
      st_d = ST_READY;
    end
  end

  // Sequencer state and engine strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q       <= ST_READY;
      cur_q      <= CMD_IDLE;
      pend_q     <= 1'b0;
      op_start_q <= 1'b0;
      op_abort_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      op_start_q <= start;
      op_abort_q <= abort_req;
      if (start) begin
        cur_q <= start_code;
      end
      if (pend_set) begin
        pend_q <= 1'b1;
      end else if (pend_clr) begin
        pend_q <= 1'b0;
      end
    end
  end
  assign op_start = op_start_q;
  assign op_code  = cur_q;
  assign op_abort = op_abort_q;
  assign sleeping = st_q == ST_SLEEP;

  // Completion flag: a write-one clear that meets a completion is held off a cycle, then clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
      fail_q <= FAIL_NONE;
    end else if (done_set) begin
      done_q <= 1'b1;
      fail_q <= fail_d;
    end else if (wr && link.addr == REG_STAT && link.wdata[STAT_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // Code-bus read ports, stalled while asleep
  for (genvar g = 0; g < 2; g++) begin : g_port
    logic user_hit;
    assign arr_addr[g] = map_addr(rd_addr[g], boot_space_alias_q);
    assign user_hit    = user_space_lock_q && in_user(arr_addr[g]);
    assign rd_ready[g] = st_q != ST_SLEEP;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        rd_rvalid[g] <= 1'b0;
        rd_fault[g]  <= 1'b0;
        rd_data[g]   <= 32'h0;
      end else begin
        rd_rvalid[g] <= rd_valid[g] && st_q != ST_SLEEP;
        rd_fault[g]  <= rd_valid[g] && st_q != ST_SLEEP && user_hit;
        rd_data[g]   <= user_hit ? 32'h0 : arr_rdata[g];
      end
    end
  end
endmodule

//--- verilog/fsc_axi_host.sv
// Purpose: AXI4-Lite slave that forwards software accesses over the link.
// Assumes: One transaction at a time; writes served before a waiting read.
// Notes:   Optional automatic key write ahead of key-protected writes.
`timescale 1ns/1ps
module fsc_axi_host (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  fsc_if.host                                  link,
  input  wire logic [fsc_pkg::AXI_ADDR_W-1:0]  awaddr,
  input  wire logic                            awvalid,
  output logic                                 awready,
  input  wire logic [31:0]                     wdata,
  input  wire logic [3:0]                      wstrb,
  input  wire logic                            wvalid,
  output logic                                 wready,
  output logic [1:0]                           bresp,
  output logic                                 bvalid,
  input  wire logic                            bready,
  input  wire logic [fsc_pkg::AXI_ADDR_W-1:0]  araddr,
  input  wire logic                            arvalid,
  output logic                                 arready,
  output logic [31:0]                          rdata,
  output logic [1:0]                           rresp,
  output logic                                 rvalid,
  input  wire logic                            rready
);
  import fsc_pkg::*;

  typedef enum logic [4:0] {
    H_IDLE  = 5'b00001,
    H_KEY   = 5'b00010,
    H_FWD   = 5'b00100,
    H_BRESP = 5'b01000,
    H_RRESP = 5'b10000
  } fsc_hstate_t;

  fsc_hstate_t  st_q;
  logic         aw_got_q;
  logic         w_got_q;
  logic [5:0]   idx_q;
  logic [31:0]  data_q;
  logic         rd_q;
  logic [1:0]   resp_q;
  logic [31:0]  rdata_q;
  logic         auto_key_q;
  logic         wr_go;
  logic         rd_go;

  // Word index names a link register
  function automatic logic is_dev(input logic [5:0] idx);
    is_dev = idx < {2'b00, REG_COUNT};
  endfunction

  // Writes that the far end honours only after the key
  function automatic logic keyed(input logic [5:0] idx);
    keyed = idx == {2'b00, REG_LOCK} || idx == {2'b00, REG_VCFG} ||
            idx == {2'b00, REG_CMD} || idx == {2'b00, REG_WRPROT};
  endfunction

  assign awready = st_q == H_IDLE && !aw_got_q;
  assign wready  = st_q == H_IDLE && !w_got_q;
  assign arready = st_q == H_IDLE && !aw_got_q && !w_got_q && !awvalid && !wvalid;
  assign wr_go   = st_q == H_IDLE && aw_got_q && w_got_q;
  assign rd_go   = arvalid && arready;

  // Link drive follows the state
  assign link.sel   = st_q == H_KEY || st_q == H_FWD;
  assign link.wr    = st_q == H_KEY || !rd_q;
  assign link.addr  = st_q == H_KEY ? REG_KEY : idx_q[REG_IDX_W-1:0];
  assign link.wdata = st_q == H_KEY ? USER_KEY : data_q;

  assign bvalid = st_q == H_BRESP;
  assign rvalid = st_q == H_RRESP;
  assign bresp  = resp_q;
  assign rresp  = resp_q;
  assign rdata  = rdata_q;

  // Capture of address and data channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      idx_q    <= 6'h0;
      data_q   <= 32'h0;
      rd_q     <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_got_q <= 1'b1;
        idx_q    <= awaddr[7:2];
        rd_q     <= 1'b0;
      end else if (rd_go) begin
        idx_q <= araddr[7:2];
        rd_q  <= 1'b1;
      end
      if (wvalid && wready) begin
        w_got_q <= 1'b1;
        for (int b = 0; b < 4; b++) begin
          data_q[8*b +: 8] <= wstrb[b] ? wdata[8*b +: 8] : 8'h0;
        end
      end
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
      end
    end
  end

  // Transaction sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q       <= H_IDLE;
      resp_q     <= RESP_OKAY;
      rdata_q    <= 32'h0;
      auto_key_q <= AUTO_KEY_RESET;
    end else begin
      unique case (st_q)
        H_IDLE: begin
          if (wr_go) begin
            resp_q <= RESP_OKAY;
            if (idx_q == HOST_CTRL_IDX) begin
              auto_key_q <= data_q[AUTO_KEY_BIT];
              st_q       <= H_BRESP;
            end else if (!is_dev(idx_q)) begin
              resp_q <= RESP_SLVERR;
              st_q   <= H_BRESP;
            end else if (auto_key_q && keyed(idx_q)) begin
              st_q <= H_KEY;
            end else begin
              st_q <= H_FWD;
            end
          end else if (rd_go) begin
            resp_q <= RESP_OKAY;
            if (araddr[7:2] == HOST_CTRL_IDX) begin
              rdata_q <= {31'h0, auto_key_q};
              st_q    <= H_RRESP;
            end else if (!is_dev(araddr[7:2])) begin
              rdata_q <= 32'h0;
              resp_q  <= RESP_SLVERR;
              st_q    <= H_RRESP;
            end else begin
              st_q <= H_FWD;
            end
          end
        end
        H_KEY: begin
          if (link.ack) begin
            st_q <= H_FWD;
          end
        end
        H_FWD: begin
          if (link.ack) begin
            if (rd_q) begin
              rdata_q <= link.rdata;
              st_q    <= H_RRESP;
            end else begin
              st_q <= H_BRESP;
            end
          end
        end
        H_BRESP: begin
          if (bready) begin
            st_q <= H_IDLE;
          end
        end
        H_RRESP: begin
          if (rready) begin
            st_q <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule

//--- tb/fsc_link_monitor.sv
// Purpose: Link checks between host bridge and flash end.
// Assumes: One clock, sync active-low reset.
// Notes:   Sees interface signals only.
`timescale 1ns/1ps
module fsc_link_monitor
  import fsc_pkg::*;
(
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 sel,
  input wire logic                 wr,
  input wire logic [REG_IDX_W-1:0] addr,
  input wire logic [31:0]          wdata,
  input wire logic [31:0]          rdata,
  input wire logic                 ack
);
  // Link handshake checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ack_one_pulse: assert property (ack |=> !ack) else $error("ack too long");
  a_ack_needs_sel: assert property (ack |-> sel) else $error("ack without sel");
  a_sel_held: assert property (sel && !ack |=> sel) else $error("sel dropped early");
  a_sel_release: assert property (ack |=> !sel) else $error("sel kept after ack");
  a_req_stable: assert property (sel && !ack |=> $stable({wr, addr, wdata})) else $error("request moved");
  a_ack_bounded: assert property ($rose(sel) |-> ##[1:8] ack) else $error("no ack");
  a_rdata_moves: assert property ($changed(rdata) |-> ack && !wr) else $error("rdata moved");
  a_sel_fall_ack: assert property ($fell(sel) |-> $past(ack)) else $error("sel fell w/o ack");
  // Main scenarios
  cover property (ack && wr && addr == REG_CMD);
  cover property (ack && !wr && addr == REG_STAT);
  cover property (ack && wr && addr == REG_KEY && wdata == USER_KEY);
endmodule

//--- tb/flash_security_command_control_bench.sv
// Purpose: Self-checking bench for both link ends.
// Assumes: AXI master in bench; engine signals driven here.
// Notes:   Table of register cases, then hand tests.
`timescale 1ns/1ps
module flash_security_command_control_bench;
  import fsc_pkg::*;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] m; logic [1:0] r;} fsc_row_t;
  logic aclk = 0, aresetn = 0, por_pin_rstn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  logic rd_valid [2], rd_ready [2], rd_rvalid [2], rd_fault [2];
  logic [19:0] rd_addr [2], arr_addr [2];
  logic [31:0] rd_data [2], arr_rdata [2];
  logic op_done = 0, op_ok = 0, abort_ok = 0, target_user = 0, op_start, op_abort, sleeping;
  logic [3:0] op_code;
  int err_count = 0, checked = 0, starts = 0, aborts = 0, s;
  fsc_row_t rows[12] = '{
    '{8'h08, 1'b0, 32'h1, 32'h1, RESP_OKAY},
    '{8'h08, 1'b1, 32'h1, 32'h0, RESP_OKAY},
    '{8'h08, 1'b0, 32'h1, 32'h1, RESP_OKAY},
    '{8'h00, 1'b1, USER_KEY, 32'h0, RESP_OKAY},
    '{8'h10, 1'b0, 32'h200, 32'h200, RESP_OKAY},
    '{8'h08, 1'b1, 32'h1, 32'h0, RESP_OKAY},
    '{8'h08, 1'b0, 32'h0, 32'h1, RESP_OKAY},
    '{8'h3c, 1'b0, 32'h0, 32'hffffffff, RESP_SLVERR},
    '{8'h0c, 1'b1, 32'h0, 32'h0, RESP_OKAY},
    '{8'h10, 1'b0, 32'h2, 32'h33, RESP_OKAY},
    '{8'h0c, 1'b1, 32'h1, 32'h0, RESP_OKAY},
    '{8'h10, 1'b0, 32'h32, 32'h33, RESP_OKAY}};
  fsc_if link();
  fsc_axi_host i_fsc_axi_host (.aclk, .aresetn, .link(link), .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready(1'b1), .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready(1'b1));
  fsc_flash_end i_fsc_flash_end (.aclk, .aresetn, .por_pin_rstn, .link(link), .rd_valid, .rd_addr,
    .rd_ready, .rd_rvalid, .rd_fault, .rd_data, .dma_req(1'b0), .arr_addr, .arr_rdata, .op_start,
    .op_code, .op_abort, .op_done, .op_ok, .abort_ok, .target_user, .target_page(5'h0), .sleeping);
  fsc_link_monitor i_fsc_link_monitor (.aclk, .aresetn, .sel(link.sel), .wr(link.wr),
    .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));
  // Array model and clock
  assign arr_rdata[0] = {12'h0, arr_addr[0]} ^ 32'h5a000000;
  assign arr_rdata[1] = {12'h0, arr_addr[1]} ^ 32'h5a000000;
  initial forever #25 aclk = ~aclk;
  // Engine strobe counts, sampled mid-cycle where the flops stand
  always @(negedge aclk) begin
    if (op_start) starts++;
    if (op_abort) aborts++;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Handshakes are judged mid-cycle, where they stand for the next edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic aw_hs, w_hs, b_hs;
    n = 0;
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
    forever begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      if (b_hs) r = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) break;
      if (++n > 100) begin err_count++; break; end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    logic ar_hs, r_hs;
    n = 0;
    araddr <= a; arvalid <= 1'b1;
    forever begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_hs = rvalid;
      if (r_hs) begin d = rdata; r = rresp; end
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) break;
      if (++n > 100) begin err_count++; break; end
    end
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axi_rd(a);
    chk(n, e, d & m);
  endtask
  // Code-bus read: handshake, then result one edge later
  task automatic bus_rd(input int i, input logic [19:0] a, input logic [31:0] e, input logic f);
    int n;
    logic hs, got;
    n = 0;
    rd_valid[i] <= 1'b1; rd_addr[i] <= a;
    forever begin
      @(negedge aclk);
      hs = rd_valid[i] && rd_ready[i];
      got = rd_rvalid[i];
      if (got) begin
        chk("bus_fault", {31'h0, f}, {31'h0, rd_fault[i]});
        chk("bus_data", e, rd_data[i]);
      end
      @(posedge aclk);
      if (hs) rd_valid[i] <= 1'b0;
      if (got) break;
      if (++n > 50) begin err_count++; break; end
    end
  endtask
  task automatic pulse_rst();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic finish_op();
    op_ok <= 1'b1; op_done <= 1'b1;
    @(posedge aclk);
    op_done <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    end_of_test();
  end
  // Main sequence
  initial begin
    rd_valid = '{1'b0, 1'b0}; rd_addr = '{20'h0, 20'h0};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1; por_pin_rstn <= 1'b1;
    @(posedge aclk);
    foreach (rows[k]) begin
      if (rows[k].w) axi_wr(rows[k].a, rows[k].d);
      else rd("reg_read", rows[k].a, rows[k].m, rows[k].d);
      chk("resp", {30'h0, rows[k].r}, {30'h0, r});
    end
    $display("test table done");
    pulse_rst();
    rd("remap", 8'h08, 32'h1, 32'h1);
    rd("key_ok", 8'h10, 32'h200, 32'h0);
    bus_rd(0, 20'h00010, 32'h5a080010, 1'b0);
    bus_rd(1, 20'h80010, 32'h5a080010, 1'b0);
    axi_wr(8'h04, 32'h1);
    rd("lock_nokey", 8'h04, 32'h1, 32'h0);
    axi_wr(8'h00, USER_KEY);
    axi_wr(8'h04, 32'h1);
    rd("lock", 8'h04, 32'h1, 32'h1);
    pulse_rst();
    rd("lock_kept", 8'h04, 32'h1, 32'h1);
    // Above the alias window, so the read lands in user space
    for (int i = 0; i < 2; i++) bus_rd(i, 20'h04100, 32'h0, 1'b1);
    $display("test lock done");
    axi_wr(8'h00, USER_KEY);
    target_user <= 1'b1;
    s = starts;
    axi_wr(8'h0c, 32'h4);
    chk("no_start", s, starts);
    rd("denied", 8'h10, 32'h30, 32'h10);
    axi_wr(8'h0c, 32'h5);
    chk("erase_start", s + 1, starts);
    chk("op_code", 32'h5, {28'h0, op_code});
    rd("cmd_read", 8'h0c, 32'hf, 32'h5);
    axi_wr(8'h0c, 32'h7);
    rd("overlap", 8'h10, 32'h31, 32'h21);
    axi_wr(8'h0c, 32'h1);
    chk("abort_req", 32'h1, aborts);
    rd("declined", 8'h10, 32'h1, 32'h1);
    finish_op();
    rd("ended", 8'h10, 32'h1, 32'h0);
    axi_wr(8'h0c, 32'h5);
    abort_ok <= 1'b1;
    axi_wr(8'h0c, 32'h1);
    chk("abort_req2", 32'h2, aborts);
    rd("aborted", 8'h10, 32'h31, 32'h30);
    bus_rd(1, 20'h04000, 32'h0, 1'b1);
    $display("test commands done");
    axi_wr(8'h0c, 32'h2);
    rd("asleep", 8'h10, 32'h100, 32'h100);
    axi_wr(8'h0c, 32'h0);
    rd("idle_wake", 8'h10, 32'h130, 32'h0);
    axi_wr(8'h0c, 32'h2);
    bus_rd(1, 20'h80100, 32'h5a080100, 1'b0);
    rd("awake", 8'h10, 32'h100, 32'h0);
    $display("test sleep done");
    axi_wr(8'h14, 32'h1);
    s = starts;
    axi_wr(8'h0c, 32'h6);
    chk("mass_refused", s, starts);
    axi_wr(8'h14, 32'h0);
    axi_wr(8'h0c, 32'h7);
    finish_op();
    rd("lock_cleared", 8'h04, 32'h1, 32'h0);
    $display("test erase done");
    end_of_test();
  end
endmodule
